//--- hdl/supply_output_ctrl.sv
// output enable, regulation mode and protection source control
// assumes pins asynchronous to clk, analog limits and nv store on clk
`timescale 1ns/100ps
`default_nettype none
module supply_output_ctrl #(
	parameter int SHUT_FILTER = supply_ctrl_pkg::SHUT_FILTER_CYCLES,
	parameter int TRIG_FILTER = supply_ctrl_pkg::TRIG_FILTER_CYCLES
) (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic                     ce,
	input  wire logic [7:0]               addr,
	input  wire logic [31:0]              wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output var  logic [31:0]              rdata,
	input  wire logic                     shutdown_pin,
	input  wire logic                     trigger_pin,
	input  wire logic                     mode_pin,
	input  wire logic [4:0]               powerup_switch_field,
	input  wire logic                     reset_powerup_pin,
	input  wire supply_ctrl_pkg::limits_s analog_limits,
	input  wire supply_ctrl_pkg::nv_cfg_s nv_cfg_in,
	output var  logic                     nv_cfg_we,
	output var  supply_ctrl_pkg::nv_cfg_s nv_cfg_out,
	output var  logic                     power_stage_en,
	output var  logic                     output_enable,
	output var  logic                     output_led,
	output var  logic                     fault_indicator,
	output var  logic                     current_mode,
	output var  logic                     setpoint_zero,
	output wire supply_ctrl_pkg::limits_s guard_limits
);
	import supply_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// pin conditioning
	// ----------------------------------------------------------------
	logic       shut_lvl, trig_lvl;
	logic [6:0] pin_s1_q, pin_s2_q;
	logic       mode_lvl, rpu_lvl;
	logic [4:0] sw;

	pulse_qualifier #(.COUNT(SHUT_FILTER), .IDLE(1'b0)) u_shut (
		.clk     (clk),
		.reset   (reset),
		.ce      (ce),
		.pin     (shutdown_pin),
		.level_q (shut_lvl)
	);
	pulse_qualifier #(.COUNT(TRIG_FILTER), .IDLE(1'b1)) u_trig (
		.clk     (clk),
		.reset   (reset),
		.ce      (ce),
		.pin     (trigger_pin),
		.level_q (trig_lvl)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end
		else if (ce)
		begin
			pin_s1_q <= {mode_pin, reset_powerup_pin, powerup_switch_field};
			pin_s2_q <= pin_s1_q;
		end
	end

	always_comb
	begin
		sw       = pin_s2_q[4:0];
		rpu_lvl  = pin_s2_q[5];
		mode_lvl = pin_s2_q[6];
	end

	// ----------------------------------------------------------------
	// control state
	// ----------------------------------------------------------------
	fsm_state_e state_q, state_d;
	logic [1:0] settle_q, settle_d;
	ctrl_mode_e ctrl_q, ctrl_d;
	load_type_e load_q, load_d;
	reg_src_e   reg_src_q, reg_src_d;
	guard_src_e vsrc_q, vsrc_d, csrc_q, csrc_d;
	limits_s    dig_q, dig_d;
	logic       pol_q, pol_d, shut_q, shut_d, trig_prev_q, trig_prev_d;
	logic       out_en_d, led_d, fault_d, power_d, cur_d, zero_d, nv_we_d;
	nv_cfg_s    nv_out_d;
	logic [31:0] rdata_d;
	logic       on_cmd, off_cmd, trig_on, shut_now, mode_curr, loc_we;
	logic [3:0] loc_idx;
	preset_s    preset;
	preset_s    loc_mem [1:15];

	always_comb
	begin
		state_d     = state_q;
		settle_d    = settle_q;
		ctrl_d      = ctrl_q;
		load_d      = load_q;
		pol_d       = pol_q;
		reg_src_d   = reg_src_q;
		vsrc_d      = vsrc_q;
		csrc_d      = csrc_q;
		dig_d       = dig_q;
		nv_we_d     = 1'b0;
		nv_out_d    = nv_cfg_out;
		on_cmd      = 1'b0;
		off_cmd     = 1'b0;
		loc_we      = 1'b0;
		loc_idx     = wdata[CMD_LOC_LSB +: 4];
		preset      = loc_mem[sw[3:0] == 4'h0 ? 4'h1 : sw[3:0]];
		case (state_q)
			ST_SETTLE:
			begin
				settle_d = settle_q + 1'b1;
				if (settle_q == SETTLE_CYCLES)
					state_d = ST_APPLY;
			end
			ST_APPLY:
			begin
				state_d = ST_RUN;
				if (rpu_lvl)
				begin
					pol_d                 = ~sw[SW_POL];
					ctrl_d                = CTRL_TRIGGER;
					nv_we_d               = 1'b1;
					nv_out_d.polarity_inv = ~sw[SW_POL];
					nv_out_d.ctrl         = CTRL_TRIGGER;
				end
				else
				begin
					pol_d  = nv_cfg_in.polarity_inv;
					ctrl_d = nv_cfg_in.ctrl;
				end
				if (sw == 5'h00)
				begin
					reg_src_d = REG_EXT;
					vsrc_d    = GUARD_EXT;
					csrc_d    = GUARD_EXT;
				end
				else if (!sw[4])
				begin
					reg_src_d = preset.current_mode ? REG_CURR : REG_VOLT;
					dig_d     = preset.limits;
					vsrc_d    = GUARD_FIXED;
					csrc_d    = GUARD_FIXED;
				end
				else
				begin
					reg_src_d = sw[0] ? REG_VOLT : REG_CURR;
					vsrc_d    = GUARD_FIXED;
					csrc_d    = GUARD_FIXED;
					case (sw[3:2])
						2'b00:
						begin
							vsrc_d = GUARD_EXT;
							csrc_d = GUARD_EXT;
						end
						2'b01: dig_d = '{LIMIT_MAX, LIMIT_MIN_BOX, LIMIT_MAX, LIMIT_MIN_BOX};
						2'b10: dig_d = '{LIMIT_MIN_BOX, LIMIT_MAX, LIMIT_MIN_BOX, LIMIT_MAX};
						default: dig_d = '{LIMIT_MAX, LIMIT_MAX, LIMIT_MAX, LIMIT_MAX};
					endcase
				end
			end
			ST_RUN:
			begin
				if (wr)
				begin
					if (addr == REG_CMD)
					begin
						on_cmd  = wdata[CMD_ON_BIT];
						off_cmd = wdata[CMD_OFF_BIT];
						if (wdata[CMD_SAVE_CFG_BIT])
						begin
							nv_we_d               = 1'b1;
							nv_out_d.polarity_inv = pol_q;
							nv_out_d.ctrl         = ctrl_q;
						end
						loc_we = wdata[CMD_SAVE_LOC_BIT] && (loc_idx != 4'h0);
					end
					else if (addr == REG_CTRL)
					begin
						if (wdata[CTRL_MODE_LSB +: 2] != 2'b11)
							ctrl_d = ctrl_mode_e'(wdata[CTRL_MODE_LSB +: 2]);
						if (wdata[CTRL_LOAD_LSB +: 2] != 2'b11)
							load_d = load_type_e'(wdata[CTRL_LOAD_LSB +: 2]);
					end
					else if (addr == REG_REG_SEL)
					begin
						if (wdata[1:0] != 2'b11)
							reg_src_d = reg_src_e'(wdata[1:0]);
					end
					else if (addr == REG_GUARD_SRC)
					begin
						if (wdata[GSRC_V_LSB +: 2] != 2'b11)
							vsrc_d = guard_src_e'(wdata[GSRC_V_LSB +: 2]);
						if (wdata[GSRC_C_LSB +: 2] != 2'b11)
							csrc_d = guard_src_e'(wdata[GSRC_C_LSB +: 2]);
					end
					else if (addr[7:4] == LIMIT_PAGE && addr[1:0] == 2'b00)
						dig_d[{addr[3:2], 4'h0} +: 16] = wdata[15:0];
				end
			end
			default: state_d = ST_SETTLE;
		endcase

		shut_now    = shut_q | shut_lvl;
		shut_d      = shut_now;
		trig_on     = trig_lvl ^ pol_q;
		trig_prev_d = trig_on;
		if (state_q != ST_RUN || shut_now)
			out_en_d = 1'b0;
		else
		begin
			case (ctrl_q)
				CTRL_TRIGGER: out_en_d = trig_on;
				CTRL_STANDBY:
				begin
					if (trig_prev_q && !trig_on)
						out_en_d = 1'b0;
					else if (on_cmd)
						out_en_d = 1'b1;
					else if (off_cmd)
						out_en_d = 1'b0;
					else
						out_en_d = output_enable;
				end
				default:
				begin
					if (on_cmd)
						out_en_d = 1'b1;
					else if (off_cmd)
						out_en_d = 1'b0;
					else
						out_en_d = output_enable;
				end
			endcase
		end
		led_d     = out_en_d;
		fault_d   = shut_d;
		power_d   = !shut_d;
		mode_curr = (reg_src_d == REG_CURR) || (reg_src_d == REG_EXT && !mode_lvl);
		if (!out_en_d && load_d == LOAD_ACTIVE)
			cur_d = 1'b0;
		else if (!out_en_d && load_d == LOAD_BATTERY)
			cur_d = 1'b1;
		else
			cur_d = mode_curr;
		zero_d = !out_en_d;

		rdata_d = '0;
		if (rd)
		begin
			if (addr == REG_CTRL)
			begin
				rdata_d[CTRL_MODE_LSB +: 2] = ctrl_q;
				rdata_d[CTRL_LOAD_LSB +: 2] = load_q;
			end
			else if (addr == REG_REG_SEL)
				rdata_d[1:0] = reg_src_q;
			else if (addr == REG_GUARD_SRC)
			begin
				rdata_d[GSRC_V_LSB +: 2] = vsrc_q;
				rdata_d[GSRC_C_LSB +: 2] = csrc_q;
			end
			else if (addr[7:4] == LIMIT_PAGE && addr[1:0] == 2'b00)
				rdata_d[15:0] = dig_q[{addr[3:2], 4'h0} +: 16];
			else if (addr == REG_STATUS)
			begin
				rdata_d[ST_OUT_BIT]  = output_enable;
				rdata_d[ST_SHUT_BIT] = shut_q;
				rdata_d[ST_CURR_BIT] = current_mode;
				rdata_d[ST_POL_BIT]  = pol_q;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q         <= ST_SETTLE;
			settle_q        <= 2'h0;
			ctrl_q          <= CTRL_TRIGGER;
			load_q          <= LOAD_ACTIVE;
			pol_q           <= 1'b0;
			reg_src_q       <= REG_VOLT;
			vsrc_q          <= GUARD_EXT;
			csrc_q          <= GUARD_EXT;
			dig_q           <= '{LIMIT_MAX, LIMIT_MAX, LIMIT_MAX, LIMIT_MAX};
			shut_q          <= 1'b0;
			trig_prev_q     <= 1'b1;
			output_enable   <= 1'b0;
			output_led      <= 1'b0;
			fault_indicator <= 1'b0;
			power_stage_en  <= 1'b1;
			current_mode    <= 1'b0;
			setpoint_zero   <= 1'b1;
			nv_cfg_we       <= 1'b0;
			nv_cfg_out      <= '{1'b0, CTRL_TRIGGER};
			rdata           <= '0;
		end
		else if (ce)
		begin
			state_q         <= state_d;
			settle_q        <= settle_d;
			ctrl_q          <= ctrl_d;
			load_q          <= load_d;
			pol_q           <= pol_d;
			reg_src_q       <= reg_src_d;
			vsrc_q          <= vsrc_d;
			csrc_q          <= csrc_d;
			dig_q           <= dig_d;
			shut_q          <= shut_d;
			trig_prev_q     <= trig_prev_d;
			output_enable   <= out_en_d;
			output_led      <= led_d;
			fault_indicator <= fault_d;
			power_stage_en  <= power_d;
			current_mode    <= cur_d;
			setpoint_zero   <= zero_d;
			nv_cfg_we       <= nv_we_d;
			nv_cfg_out      <= nv_out_d;
			rdata           <= rdata_d;
		end
	end

	// preset store written by the save-location command
	always_ff @(posedge clk)
	begin
		if (ce && loc_we)
			loc_mem[loc_idx] <= '{current_mode, dig_q};
	end

	// ----------------------------------------------------------------
	// protection limit selectors
	// ----------------------------------------------------------------
	logic [63:0] guard_w;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_guard
			guard_limit_select u_sel (
				.clk     (clk),
				.reset   (reset),
				.ce      (ce),
				.src     (gi < 2 ? vsrc_q : csrc_q),
				.digital (dig_q[gi*16 +: 16]),
				.analog  (analog_limits[gi*16 +: 16]),
				.limit_q (guard_w[gi*16 +: 16])
			);
		end
	endgenerate
	assign guard_limits = guard_w;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_shut_holds;
		shut_q |=> shut_q;
	endproperty
	a_shut_holds: assert property (p_shut_holds) else $error("shutdown latch cleared");
	property p_shut_dead;
		shut_q |-> !output_enable && !power_stage_en;
	endproperty
	a_shut_dead: assert property (p_shut_dead) else $error("output alive in shutdown");
	property p_shut_fault;
		shut_q |-> fault_indicator && !output_led;
	endproperty
	a_shut_fault: assert property (p_shut_fault) else $error("fault indicator not set");
	property p_trig_off;
		ce && state_q == ST_RUN && ctrl_q == CTRL_TRIGGER && !trig_on |=> !output_enable && !output_led;
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("trigger did not disable");
	property p_trig_on;
		ce && state_q == ST_RUN && ctrl_q == CTRL_TRIGGER && trig_on && !shut_now
			|=> output_enable && output_led;
	endproperty
	a_trig_on: assert property (p_trig_on) else $error("trigger did not enable");
	property p_standby_cmd;
		ce && ctrl_q == CTRL_STANDBY && !output_enable && !on_cmd |=> !output_enable;
	endproperty
	a_standby_cmd: assert property (p_standby_cmd) else $error("standby enabled by itself");
	property p_cmd_only;
		ce && ctrl_q == CTRL_CMD_ONLY && !on_cmd && !off_cmd && !shut_now && state_q == ST_RUN
			|=> $stable(output_enable);
	endproperty
	a_cmd_only: assert property (p_cmd_only) else $error("trigger acted while disabled");
	property p_save_cfg;
		ce && state_q == ST_RUN && wr && addr == REG_CMD && wdata[CMD_SAVE_CFG_BIT]
			|=> nv_cfg_we && nv_cfg_out.ctrl == $past(ctrl_q);
	endproperty
	a_save_cfg: assert property (p_save_cfg) else $error("setting not stored");
	property p_zero_switch;
		ce && state_q == ST_APPLY && sw == 5'h00 |=> reg_src_q == REG_EXT && vsrc_q == GUARD_EXT;
	endproperty
	a_zero_switch: assert property (p_zero_switch) else $error("all-zero switches misread");
	property p_all_max;
		ce && state_q == ST_APPLY && sw[4:2] == 3'b111
			|=> dig_q.v_neg == LIMIT_MAX && dig_q.c_pos == LIMIT_MAX;
	endproperty
	a_all_max: assert property (p_all_max) else $error("limits not at maximum");
	property p_active_off;
		!output_enable && state_q == ST_RUN && load_q == LOAD_ACTIVE |-> !current_mode && setpoint_zero;
	endproperty
	a_active_off: assert property (p_active_off) else $error("active load off state wrong");
	property p_battery_off;
		!output_enable && state_q == ST_RUN && load_q == LOAD_BATTERY |-> current_mode && setpoint_zero;
	endproperty
	a_battery_off: assert property (p_battery_off) else $error("battery off state wrong");

	c_shutdown: cover property (!shut_q ##1 shut_q);
	c_standby_drop: cover property (ctrl_q == CTRL_STANDBY && output_enable ##1 !output_enable);
	c_save: cover property (nv_cfg_we && state_q == ST_RUN);
	c_lesser: cover property (vsrc_q == GUARD_MIN && output_enable);
endmodule
`default_nettype wire

//--- hdl/supply_ctrl_pkg.sv
// constants, types and register map of the output and mode control block
// assumes one 200 MHz clock domain and a plain strobe register port
package supply_ctrl_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 5;
	localparam int SYNC_STAGES       = 2;
	localparam int SHUT_MIN_US       = 100;
	localparam int TRIG_PULSE_MIN_US = 100;
	// filters equal to the least pulse minus synchroniser latency
	localparam int SHUT_FILTER_CYCLES = SHUT_MIN_US * 1000 / CLK_PERIOD_NS - SYNC_STAGES;
	localparam int TRIG_FILTER_CYCLES = TRIG_PULSE_MIN_US * 1000 / CLK_PERIOD_NS - SYNC_STAGES;
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] REG_CMD       = 8'h00;
	localparam logic [7:0] REG_CTRL      = 8'h04;
	localparam logic [7:0] REG_REG_SEL   = 8'h08;
	localparam logic [7:0] REG_GUARD_SRC = 8'h0C;
	localparam logic [3:0] LIMIT_PAGE    = 4'h1;
	localparam logic [7:0] REG_STATUS    = 8'h20;
	localparam int CMD_ON_BIT       = 0;
	localparam int CMD_OFF_BIT      = 1;
	localparam int CMD_SAVE_CFG_BIT = 2;
	localparam int CMD_SAVE_LOC_BIT = 3;
	localparam int CMD_LOC_LSB      = 4;
	localparam int CTRL_MODE_LSB    = 0;
	localparam int CTRL_LOAD_LSB    = 2;
	localparam int GSRC_V_LSB       = 0;
	localparam int GSRC_C_LSB       = 2;
	localparam int ST_OUT_BIT       = 0;
	localparam int ST_SHUT_BIT      = 1;
	localparam int ST_CURR_BIT      = 2;
	localparam int ST_POL_BIT       = 3;

	// ----------------------------------------------------------------
	// switch field and limit codes
	// ----------------------------------------------------------------
	localparam int SW_W    = 5;
	localparam int SW_POL  = 4;
	localparam int LIM_W   = 16;
	localparam logic [15:0] LIMIT_MAX     = 16'hFFFF;
	localparam logic [15:0] LIMIT_MIN_BOX = 16'h1999;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {CTRL_TRIGGER = 2'b00, CTRL_STANDBY = 2'b01,
		CTRL_CMD_ONLY = 2'b10} ctrl_mode_e;
	typedef enum logic [1:0] {LOAD_ACTIVE = 2'b00, LOAD_RESISTIVE = 2'b01,
		LOAD_BATTERY = 2'b10} load_type_e;
	typedef enum logic [1:0] {REG_VOLT = 2'b00, REG_CURR = 2'b01, REG_EXT = 2'b10} reg_src_e;
	typedef enum logic [1:0] {GUARD_FIXED = 2'b00, GUARD_EXT = 2'b01,
		GUARD_MIN = 2'b10} guard_src_e;
	typedef enum logic [1:0] {ST_SETTLE = 2'b00, ST_APPLY = 2'b01, ST_RUN = 2'b10} fsm_state_e;
	typedef struct packed {
		logic [15:0] c_neg;
		logic [15:0] c_pos;
		logic [15:0] v_neg;
		logic [15:0] v_pos;
	} limits_s;
	typedef struct packed {
		logic       polarity_inv;
		ctrl_mode_e ctrl;
	} nv_cfg_s;
	typedef struct packed {
		logic    current_mode;
		limits_s limits;
	} preset_s;
endpackage

//--- hdl/pulse_qualifier.sv
// two-stage synchroniser and pulse-width filter for one pin
// assumes the pin is asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module pulse_qualifier #(
	parameter int   COUNT = 19998,
	parameter logic IDLE  = 1'b0
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic ce,
	input  wire logic pin,
	output var  logic level_q
);
	import supply_ctrl_pkg::*;
	localparam int CW = $clog2(COUNT + 1);
	logic [1:0]    sync_q, sync_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          level_d;

	always_comb
	begin
		sync_d  = {sync_q[0], pin};
		level_d = level_q;
		cnt_d   = '0;
		if (sync_q[1] != level_q)
		begin
			if (cnt_q == CW'(COUNT - 1))
				level_d = sync_q[1];
			else
				cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sync_q  <= {IDLE, IDLE};
			cnt_q   <= '0;
			level_q <= IDLE;
		end
		else if (ce)
		begin
			sync_q  <= sync_d;
			cnt_q   <= cnt_d;
			level_q <= level_d;
		end
	end

	property p_filter_holds;
		@(posedge clk) disable iff (reset)
		!ce || (cnt_q != CW'(COUNT - 1)) |=> $stable(level_q);
	endproperty
	a_filter_holds: assert property (p_filter_holds) else $error("level moved before filter");
endmodule
`default_nettype wire

//--- hdl/guard_limit_select.sv
// picks one protection limit from digital setting, analog input or lesser
// assumes analog values arrive already digitised on clk
`timescale 1ns/100ps
`default_nettype none
module guard_limit_select (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        ce,
	input  wire supply_ctrl_pkg::guard_src_e src,
	input  wire logic [15:0]                 digital,
	input  wire logic [15:0]                 analog,
	output var  logic [15:0]                 limit_q
);
	import supply_ctrl_pkg::*;
	logic [15:0] limit_d;

	always_comb
	begin
		limit_d = limit_q;
		case (src)
			GUARD_FIXED: limit_d = digital;
			GUARD_EXT:   limit_d = analog;
			GUARD_MIN:   limit_d = (digital < analog) ? digital : analog;
			default:     limit_d = limit_q;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			limit_q <= LIMIT_MAX;
		else if (ce)
			limit_q <= limit_d;
	end

	property p_fixed;
		@(posedge clk) disable iff (reset)
		ce && !reset && src == GUARD_FIXED |=> limit_q == $past(digital);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed limit wrong");
	property p_ext;
		@(posedge clk) disable iff (reset)
		ce && !reset && src == GUARD_EXT |=> limit_q == $past(analog);
	endproperty
	a_ext: assert property (p_ext) else $error("external limit wrong");
	property p_min;
		@(posedge clk) disable iff (reset)
		ce && !reset && src == GUARD_MIN |=> limit_q <= $past(digital) && limit_q <= $past(analog)
			&& (limit_q == $past(digital) || limit_q == $past(analog));
	endproperty
	a_min: assert property (p_min) else $error("lesser limit wrong");
endmodule
`default_nettype wire

//--- verification/pin_pulser.sv
// far-side pin model: drives an interlock or trigger pin away from idle
// assumes fire is a one-cycle request on clk
`timescale 1ns/100ps
`default_nettype none
module pin_pulser (
	input  wire logic       clk,
	input  wire logic       fire,
	input  wire logic [7:0] width,
	input  wire logic       idle,
	output var  logic       pin
);
	logic [7:0] left_q;
	initial left_q = 8'h00;
	always @(posedge clk)
		left_q <= fire ? width : ((left_q != 8'h00) ? left_q - 8'h01 : 8'h00);
	assign pin = (left_q != 8'h00) ? ~idle : idle;
endmodule
`default_nettype wire

//--- verification/tb_supply_output_ctrl.sv
// bench for the output and mode control block
// assumes filters of 8 cycles, straps 11111 at a reset power-up
`timescale 1ns/100ps
`default_nettype none
module tb_supply_output_ctrl;
	import supply_ctrl_pkg::*;
	logic clk = 0, reset = 1, wr = 0, rd = 0, fs = 0, ft = 0, shut, trig;
	logic ce = 1, mp = 1, rpu = 1;
	logic [4:0] sw = 5'b11111;
	nv_cfg_s nvi = 3'b000;
	localparam logic [63:0] POS_MAX = {LIMIT_MIN_BOX, LIMIT_MAX, LIMIT_MIN_BOX, LIMIT_MAX};
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	limits_s ana = 64'h0;
	limits_s lim;
	nv_cfg_s nvo;
	logic nwe, pse, oe, led, flt, cm, sz;
	int n_errors = 0, comparisons = 0, ticks = 0;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [17:0] e;} row_s;
	row_s rows [11] = '{
		'{REG_CMD, 32'h2, {2'b00, 16'hFFFF}}, '{REG_REG_SEL, 32'h1, {2'b00, 16'hFFFF}},
		'{REG_CMD, 32'h1, {2'b11, 16'hFFFF}}, '{REG_REG_SEL, 32'h0, {2'b10, 16'hFFFF}},
		'{8'h10, 32'h1234, {2'b10, 16'h1234}}, '{REG_GUARD_SRC, 32'h1, {2'b10, 16'h0100}},
		'{REG_GUARD_SRC, 32'h2, {2'b10, 16'h0100}}, '{8'h10, 32'h0050, {2'b10, 16'h0050}},
		'{REG_CTRL, 32'hA, {2'b10, 16'h0050}}, '{REG_CMD, 32'h2, {2'b01, 16'h0050}},
		'{REG_CMD, 32'h1, {2'b10, 16'h0050}}};
	always #2.5 clk = ~clk;
	pin_pulser u_shut (.clk(clk), .fire(fs), .width(8'd16), .idle(1'b0), .pin(shut));
	pin_pulser u_trig (.clk(clk), .fire(ft), .width(8'd255), .idle(1'b1), .pin(trig));
	supply_output_ctrl #(.SHUT_FILTER(8), .TRIG_FILTER(8)) u_supply_output_ctrl (
		.clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .shutdown_pin(shut), .trigger_pin(trig),
		.mode_pin(mp), .powerup_switch_field(sw), .reset_powerup_pin(rpu),
		.analog_limits(ana), .nv_cfg_in(nvi), .nv_cfg_we(nwe),
		.nv_cfg_out(nvo), .power_stage_en(pse), .output_enable(oe), .output_led(led),
		.fault_indicator(flt), .current_mode(cm), .setpoint_zero(sz), .guard_limits(lim));
	task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 v = rdata;
	endtask
	task automatic fire(bit s);
		@(posedge clk);
		if (s)
			fs <= 1;
		else
			ft <= 1;
		@(posedge clk);
		fs <= 0;
		ft <= 0;
	endtask
	task automatic pwr(logic [4:0] s, logic r, logic [2:0] n);
		@(posedge clk);
		reset <= 1;
		sw <= s;
		rpu <= r;
		nvi <= n;
		cyc(12);
		reset <= 0;
		cyc(30);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		ticks++;
		if (ticks == 4000)
		begin
			n_errors++;
			close_out();
		end
	end
	initial
	begin
		cyc(12);
		reset <= 0;
		cyc(30);
		chk("limits", lim, {4{16'hFFFF}});
		chk("oe led cm", {oe, led, cm}, 3'b110);
		fire(0);
		cyc(20);
		chk("oe led", {oe, led}, 2'b00);
		cyc(260);
		chk("oe", oe, 1'b1);
		wreg(REG_CMD, 32'h2);
		cyc(2);
		chk("trig wins", oe, 1'b1);
		$display("trigger mode done");
		wreg(REG_CTRL, 32'h2);
		ana.v_pos <= 16'h0100;
		fire(0);
		cyc(20);
		foreach (rows[i])
		begin
			wreg(rows[i].a, rows[i].d);
			cyc(3);
			chk("oe cm vpos", {oe, cm, lim.v_pos}, rows[i].e);
		end
		$display("table done");
		cyc(260);
		wreg(REG_CTRL, 32'h1);
		fire(0);
		cyc(20);
		chk("standby off", {oe, sz}, 2'b01);
		cyc(260);
		chk("standby stays", oe, 1'b0);
		wreg(REG_CMD, 32'h1);
		cyc(3);
		chk("standby on", {oe, sz}, 2'b10);
		ce <= 0;
		wreg(REG_CMD, 32'h2);
		cyc(2);
		chk("frozen", oe, 1'b1);
		ce <= 1;
		wreg(REG_CMD, 32'h4);
		for (int k = 0; k < 4 && nwe !== 1'b1; k++)
			cyc(1);
		chk("save", {nwe, nvo.ctrl}, {1'b1, CTRL_STANDBY});
		rreg(REG_STATUS);
		chk("status", v, 32'h1);
		rreg(8'hFC);
		chk("unmapped", v, 32'h0);
		$display("standby done");
		fire(1);
		cyc(30);
		chk("shutdown", {pse, flt, oe, led}, 4'b0100);
		wreg(REG_CMD, 32'h1);
		cyc(30);
		chk("latched", {pse, flt, oe}, 3'b010);
		$display("shutdown done");
		pwr(5'b10101, 1'b0, 3'b001);
		chk("restored", {pse, flt, oe}, 3'b100);
		chk("limits", lim, {LIMIT_MAX, LIMIT_MIN_BOX, LIMIT_MAX, LIMIT_MIN_BOX});
		rreg(REG_CTRL);
		chk("stored ctrl", v, 32'h1);
		wreg(REG_CMD, 32'h1);
		cyc(2);
		chk("oe cm", {oe, cm}, 2'b10);
		pwr(5'b11010, 1'b1, 3'b000);
		chk("limits", lim, POS_MAX);
		chk("oe cm", {oe, cm}, 2'b11);
		wreg(REG_CMD, 32'h38);
		pwr(5'b00011, 1'b0, 3'b000);
		chk("preset", lim, POS_MAX);
		chk("oe cm", {oe, cm}, 2'b11);
		mp <= 0;
		pwr(5'b00000, 1'b1, 3'b000);
		chk("analog", lim, ana);
		chk("inverted", {oe, nvo}, 4'b0100);
		fire(0);
		cyc(20);
		chk("pin mode", {oe, cm}, 2'b11);
		$display("power-up done");
		close_out();
	end
endmodule
`default_nettype wire
